// ===== rtl/cfgld_pkg.sv
// package of constants for the configuration load sequencer
// assumes a 200 MHz core clock and a synchronous, active-high reset
package cfgld_pkg;
   // ----------------------------------------
   // clock and times
   // ----------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int RESET_MIN_NS = 320;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int FIRST_DATA_DELAY_NS = 1200;
   localparam int FIRST_DATA_DELAY_CYC = (FIRST_DATA_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int USER_DELAY_US = 12;
   localparam int USER_DELAY_CYC = USER_DELAY_US * CLK_MHZ;
   // active clock: 200/10 = 20 MHz, 200/20 = 10 MHz with divide-by-eight setting
   localparam int ACTIVE_CLOCK_RATE_MHZ = 20;
   localparam int ACTIVE_HALF_CYC = CLK_MHZ / ACTIVE_CLOCK_RATE_MHZ / 2;
   localparam int SLOW_CLOCK_RATE_MHZ = 10;
   localparam int SLOW_HALF_CYC = CLK_MHZ / SLOW_CLOCK_RATE_MHZ / 2;
   localparam int PASSIVE_CLOCK_LIMIT_X1_MHZ = 25;
   localparam int PASSIVE_CLOCK_LIMIT_WIDE_MHZ = 50;
   // ----------------------------------------
   // widths and sizes
   // ----------------------------------------
   localparam int CNT_W = 16;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam logic [31:0] BITSTREAM_BYTES_DEF = 32'h0000_0100;
   // ----------------------------------------
   // modes and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      CFGLD_MODE_ACTIVE = 2'h0,
      CFGLD_MODE_PASSIVE = 2'h1,
      CFGLD_MODE_TAP = 2'h2
   } cfgld_mode_e;
   typedef enum logic [5:0] {
      CFGLD_IDLE = 6'h01,
      CFGLD_RESET = 6'h02,
      CFGLD_WAIT = 6'h04,
      CFGLD_LOAD = 6'h08,
      CFGLD_DONE = 6'h10,
      CFGLD_USER = 6'h20
   } cfgld_state_e;
endpackage

// ===== rtl/cfgld_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes one clock; read data come from a register
`timescale 1ns/1ps
module cfgld_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic [WIDTH-1:0] out_data_ff, nxt_out_data;
   logic out_valid_ff, nxt_out_valid;
   logic push, pop, load;

   // ----------------------------------------
   // handshake
   // ----------------------------------------
   // output register counts as one stage, so storage holds DEPTH words beyond it
   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign push = in_valid && in_ready;
   assign load = !out_valid_ff || out_ready;
   assign pop = load && (cnt_ff != '0);
   assign out_valid = out_valid_ff;
   assign out_data = out_data_ff;

   // next pointers, count and output stage
   always_comb begin
      nxt_wr = push ? wr_ff + AW'(1) : wr_ff;
      nxt_rd = pop ? rd_ff + AW'(1) : rd_ff;
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      nxt_out_valid = load ? pop : out_valid_ff;
      nxt_out_data = pop ? mem_ff[rd_ff] : out_data_ff;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         out_valid_ff <= 1'b0;
         out_data_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         out_valid_ff <= nxt_out_valid;
         out_data_ff <= nxt_out_data;
      end
   end

   // storage has no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
endmodule

// ===== rtl/cfgld_seq.sv
// configuration load sequencer: reset pulse check, first-data delay, active
// clock generation, byte capture through a fifo, completion and user entry
// assumes all inputs synchronous to clk; spi and tap pins already sampled
//
// Notes on behaviour
// - user mode follows config_complete high by at least 12 us
// - tap load counts user delay after complete and enter_user_instruction
// - active clock 20 MHz nominal, 10 MHz with divide_by_eight_setting
// - no data accepted before 1.2 us after config reset release
`timescale 1ns/1ps
module cfgld_seq
   import cfgld_pkg::*;
#(
   parameter logic [31:0] BITSTREAM_BYTES = BITSTREAM_BYTES_DEF
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic config_reset_n,
   input wire logic [1:0] mode,
   input wire logic divide_by_eight_setting,
   output logic active_clk,
   output logic flash_select_n,
   input wire logic spi_clk_rise,
   input wire logic [DATA_W-1:0] spi_data,
   input wire logic spi_data_valid,
   input wire logic tap_active,
   input wire logic [DATA_W-1:0] tap_data,
   input wire logic tap_data_valid,
   input wire logic enter_user_instruction,
   output logic [DATA_W-1:0] cfg_data,
   output logic cfg_valid,
   input wire logic cfg_ready,
   output logic config_complete,
   output logic user_mode,
   output logic pin_conflict,
   output logic load_overrun
);
   // ----------------------------------------
   // state and counters
   // ----------------------------------------
   cfgld_state_e state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [CNT_W-1:0] low_ff, nxt_low;
   logic [31:0] bytes_ff, nxt_bytes;
   logic [7:0] div_ff, nxt_div;
   logic aclk_ff, nxt_aclk;
   logic seen_enter_ff, nxt_seen_enter;
   logic conflict_ff, nxt_conflict;
   logic overrun_ff, nxt_overrun;
   logic complete_ff, nxt_complete;
   logic user_ff, nxt_user;
   logic [DATA_W-1:0] in_data;
   logic in_valid, in_ready, push;
   cfgld_mode_e mode_e;

   // saturating increment used by the state and reset-low counters; bytes_ff and div_ff wrap
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      return (v == '1) ? v : v + CNT_W'(1);
   endfunction

   assign mode_e = cfgld_mode_e'(mode);

   // ----------------------------------------
   // data source select
   // ----------------------------------------
   // only the selected port feeds the loader; the other is watched for misuse
   always_comb begin
      unique case (mode_e)
         CFGLD_MODE_TAP: begin
            in_data = tap_data;
            in_valid = tap_data_valid;
         end
         default: begin
            in_data = spi_data;
            in_valid = spi_data_valid && spi_clk_rise;
         end
      endcase
   end

   // bytes enter only during the load window, after the first-data delay
   assign push = in_valid && in_ready && (state_ff == CFGLD_LOAD);

   cfgld_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .reset(reset || state_ff == CFGLD_RESET),
      .in_data(in_data),
      .in_valid(in_valid && state_ff == CFGLD_LOAD),
      .in_ready(in_ready),
      .out_data(cfg_data),
      .out_valid(cfg_valid),
      .out_ready(cfg_ready)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // reset pulse shorter than the minimum is ignored rather than half-starting
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_bytes = bytes_ff;
      nxt_seen_enter = seen_enter_ff;
      nxt_complete = complete_ff;
      nxt_user = user_ff;
      // low time of the config reset, counted apart from the state
      nxt_low = config_reset_n ? '0 : sat_inc(low_ff);
      unique case (state_ff)
         CFGLD_IDLE, CFGLD_USER: begin
            nxt_cnt = '0;
         end
         CFGLD_RESET: begin
            nxt_complete = 1'b0;
            nxt_user = 1'b0;
            nxt_seen_enter = 1'b0;
            nxt_bytes = '0;
            nxt_cnt = '0;
            if (config_reset_n) begin
               nxt_state = CFGLD_WAIT;
            end
         end
         CFGLD_WAIT: begin
            nxt_cnt = sat_inc(cnt_ff);
            if (cnt_ff >= CNT_W'(FIRST_DATA_DELAY_CYC - 1)) begin
               nxt_state = CFGLD_LOAD;
               nxt_cnt = '0;
            end
         end
         CFGLD_LOAD: begin
            if (push) begin
               nxt_bytes = bytes_ff + 32'h0000_0001;
            end
            if (push && bytes_ff == BITSTREAM_BYTES - 32'h0000_0001) begin
               nxt_state = CFGLD_DONE;
               nxt_complete = 1'b1;
               nxt_cnt = '0;
            end
         end
         CFGLD_DONE: begin
            if (mode_e == CFGLD_MODE_TAP && enter_user_instruction) begin
               nxt_seen_enter = 1'b1;
            end
            // tap loads start counting only once the instruction arrived
            if (mode_e != CFGLD_MODE_TAP || seen_enter_ff) begin
               nxt_cnt = sat_inc(cnt_ff);
            end
            if (cnt_ff >= CNT_W'(USER_DELAY_CYC)) begin
               nxt_state = CFGLD_USER;
               nxt_user = 1'b1;
            end
         end
         default: begin
            nxt_state = CFGLD_IDLE;
            nxt_cnt = '0;
         end
      endcase
      // a pulse counts once it reaches the minimum, from any state;
      // shorter pulses leave state, completion and user mode untouched
      if (!config_reset_n && low_ff >= CNT_W'(RESET_MIN_CYC - 1)) begin
         nxt_state = CFGLD_RESET;
         nxt_complete = 1'b0;
         nxt_user = 1'b0;
         nxt_cnt = '0;
      end
      if (reset) begin
         nxt_state = CFGLD_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= CFGLD_IDLE;
         cnt_ff <= '0;
         bytes_ff <= '0;
         seen_enter_ff <= 1'b0;
         complete_ff <= 1'b0;
         user_ff <= 1'b0;
         low_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         bytes_ff <= nxt_bytes;
         seen_enter_ff <= nxt_seen_enter;
         complete_ff <= nxt_complete;
         user_ff <= nxt_user;
         low_ff <= nxt_low;
      end
   end

   // ----------------------------------------
   // active clock divider
   // ----------------------------------------
   // runs only while loading in active mode so the flash sees no stray edges
   always_comb begin
      nxt_div = div_ff;
      nxt_aclk = aclk_ff;
      if (state_ff == CFGLD_LOAD && mode_e == CFGLD_MODE_ACTIVE) begin
         if (div_ff >= 8'((divide_by_eight_setting ? SLOW_HALF_CYC : ACTIVE_HALF_CYC) - 1)) begin
            nxt_div = '0;
            nxt_aclk = !aclk_ff;
         end else begin
            nxt_div = div_ff + 8'h01;
         end
      end else begin
         nxt_div = '0;
         nxt_aclk = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div_ff <= '0;
         aclk_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         aclk_ff <= nxt_aclk;
      end
   end

   // ----------------------------------------
   // misuse monitors
   // ----------------------------------------
   // sticky until the next reconfiguration; set wins over the clear
   always_comb begin
      nxt_conflict = conflict_ff;
      nxt_overrun = overrun_ff;
      if (state_ff == CFGLD_RESET) begin
         nxt_conflict = 1'b0;
         nxt_overrun = 1'b0;
      end
      if (state_ff == CFGLD_WAIT || state_ff == CFGLD_LOAD) begin
         if (mode_e != CFGLD_MODE_TAP && (tap_active || tap_data_valid)) begin
            nxt_conflict = 1'b1;
         end
         if (mode_e == CFGLD_MODE_TAP && spi_data_valid) begin
            nxt_conflict = 1'b1;
         end
      end
      // a byte that finds the fifo full, or comes too early, is lost
      if (in_valid && ((state_ff == CFGLD_LOAD && !in_ready) || state_ff == CFGLD_WAIT)) begin
         nxt_overrun = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         conflict_ff <= 1'b0;
         overrun_ff <= 1'b0;
      end else begin
         conflict_ff <= nxt_conflict;
         overrun_ff <= nxt_overrun;
      end
   end

   assign active_clk = aclk_ff;
   assign flash_select_n = !(state_ff == CFGLD_LOAD && mode_e == CFGLD_MODE_ACTIVE);
   assign config_complete = complete_ff;
   assign user_mode = user_ff;
   assign pin_conflict = conflict_ff;
   assign load_overrun = overrun_ff;
endmodule

// ===== testbench/cfgld_checker.sv
// port timing checker for the configuration load sequencer
// assumes it is bound to cfgld_seq and shares its single clock
`timescale 1ns/1ps
module cfgld_checker
   import cfgld_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic config_reset_n,
   input wire logic divide_by_eight_setting,
   input wire logic active_clk,
   input wire logic flash_select_n,
   input wire logic tap_active,
   input wire logic cfg_valid,
   input wire logic config_complete,
   input wire logic user_mode,
   input wire logic pin_conflict
);
   logic [CNT_W-1:0] rel_ff;
   logic [CNT_W-1:0] nxt_rel;
   logic [CNT_W-1:0] done_ff;
   logic [CNT_W-1:0] nxt_done;
   // saturating counts since release and since completion
   always_comb begin
      nxt_rel = !config_reset_n ? '0 : (rel_ff == '1 ? rel_ff : rel_ff + 1'h1);
      nxt_done = !config_complete ? '0 : (done_ff == '1 ? done_ff : done_ff + 1'h1);
   end
   always_ff @(posedge clk) begin
      rel_ff <= reset ? '0 : nxt_rel;
      done_ff <= reset ? '0 : nxt_done;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_no_early_data: assert property (cfg_valid |-> rel_ff >= FIRST_DATA_DELAY_CYC)
      else $error("data before first-data delay");
   a_select_delay: assert property ($fell(flash_select_n) |-> rel_ff >= FIRST_DATA_DELAY_CYC)
      else $error("flash selected too early");
   a_user_delay: assert property ($rose(user_mode) |-> done_ff >= USER_DELAY_CYC)
      else $error("user mode too early");
   a_user_complete: assert property (user_mode |-> config_complete)
      else $error("user mode without completion");
   a_complete_holds: assert property ($fell(config_complete) |-> !$past(config_reset_n) || !$past(config_reset_n, 2))
      else $error("completion dropped without reset");
   a_no_complete_load: assert property (!flash_select_n |-> !config_complete)
      else $error("completion during load");
   a_clk_idle: assert property (flash_select_n && $past(flash_select_n, 2) |-> !active_clk)
      else $error("active clock outside load");
   a_half_fast: assert property ($rose(active_clk) && !divide_by_eight_setting |->
      active_clk [*5] ##1 !active_clk or ##[0:5] flash_select_n) else $error("fast half period wrong");
   a_half_slow: assert property ($rose(active_clk) && divide_by_eight_setting |->
      active_clk [*8] ##1 active_clk [*2] ##1 !active_clk or ##[0:10] flash_select_n) else $error("slow half period wrong");
   a_conflict_set: assert property (tap_active && !flash_select_n |-> ##[1:2] pin_conflict)
      else $error("conflict not flagged");
endmodule
bind cfgld_seq cfgld_checker cfgld_checker_inst (.clk, .reset, .config_reset_n, .divide_by_eight_setting,
   .active_clk, .flash_select_n, .tap_active, .cfg_valid, .config_complete, .user_mode, .pin_conflict);

// ===== testbench/cfgld_flash_model.sv
// flash memory model: one byte per active clock rise while selected, every second rise when slow;
// in passive mode it stands in for the host and drives its own clock
// assumes flash_select_n and active_clk come from the sequencer
`timescale 1ns/1ps
module cfgld_flash_model
   import cfgld_pkg::*;
(
   input wire logic clk,
   input wire logic active_clk,
   input wire logic flash_select_n,
   input wire logic slow,
   input wire logic host_drive,
   input wire logic config_reset_n,
   output logic spi_clk_rise,
   output logic [DATA_W-1:0] spi_data,
   output logic spi_data_valid
);
   // host clock half period at the single-bit limit: 4 core cycles, 40 ns period
   localparam int HOST_HALF_CYC = CLK_MHZ / PASSIVE_CLOCK_LIMIT_X1_MHZ / 2;
   // host waits a little past the first-data delay before its first edge
   localparam int HOST_START_CYC = FIRST_DATA_DELAY_CYC + 4;
   logic clk_q = 1'h0;
   logic skip = 1'h0;
   logic host_clk = 1'h0;
   logic [DATA_W-1:0] idx = '0;
   int host_cnt = 0;
   int quiet = 0;
   initial begin
      spi_clk_rise = 1'h0;
      spi_data = '0;
      spi_data_valid = 1'h0;
   end
   // released bus shows inverted data so stale bytes never look valid
   always @(posedge clk) begin
      clk_q <= active_clk;
      spi_clk_rise <= 1'h0;
      quiet <= config_reset_n ? quiet + 1 : 0;
      if (host_drive) begin
         // host clock stands still outside its eight-byte frame
         if (!config_reset_n || quiet < HOST_START_CYC || idx == 8'h08) begin
            host_clk <= 1'h0;
            host_cnt <= 0;
            spi_data_valid <= 1'h0;
            spi_data <= ~spi_data;
            if (!config_reset_n) idx <= '0;
         end else if (host_cnt == HOST_HALF_CYC - 1) begin
            host_cnt <= 0;
            host_clk <= !host_clk;
            if (!host_clk) begin
               spi_clk_rise <= 1'h1;
               spi_data_valid <= 1'h1;
               spi_data <= 8'hb0 + idx;
               idx <= idx + 8'h01;
            end
         end else begin
            host_cnt <= host_cnt + 1;
         end
      end else if (flash_select_n) begin
         spi_data_valid <= 1'h0;
         spi_data <= ~spi_data;
         idx <= '0;
      end else if (active_clk && !clk_q) begin
         skip <= ~skip;
         if (!(slow && skip)) begin
            spi_clk_rise <= 1'h1;
            spi_data_valid <= 1'h1;
            spi_data <= 8'ha0 + idx;
            idx <= idx + 8'h01;
         end
      end
   end
endmodule

// ===== testbench/testbench.sv
// self-checking bench of the load sequencer with a flash model
// assumes an 8-byte bitstream and the 200 MHz core clock
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module testbench
   import cfgld_pkg::*;
;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic config_reset_n = 1'h1;
   logic [1:0] mode = 2'h0;
   logic divide_by_eight_setting = 1'h0;
   logic slow = 1'h0;
   logic tap_active = 1'h0;
   logic [DATA_W-1:0] tap_data = '0;
   logic tap_data_valid = 1'h0;
   logic enter_user_instruction = 1'h0;
   logic cfg_ready = 1'h1;
   logic active_clk, flash_select_n, spi_clk_rise, spi_data_valid, cfg_valid;
   logic config_complete, user_mode, pin_conflict, load_overrun;
   logic [DATA_W-1:0] spi_data, cfg_data;
   logic [DATA_W-1:0] rx_q[$];
   logic [3:0] watch;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   assign watch = {!flash_select_n, config_complete, user_mode, active_clk};
   cfgld_seq #(.BITSTREAM_BYTES(32'h0000_0008)) cfgld_seq_inst (.clk(clk), .reset(reset),
      .config_reset_n(config_reset_n), .mode(mode), .divide_by_eight_setting(divide_by_eight_setting),
      .active_clk(active_clk), .flash_select_n(flash_select_n), .spi_clk_rise(spi_clk_rise),
      .spi_data(spi_data), .spi_data_valid(spi_data_valid), .tap_active(tap_active), .tap_data(tap_data),
      .tap_data_valid(tap_data_valid), .enter_user_instruction(enter_user_instruction), .cfg_data(cfg_data),
      .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .config_complete(config_complete),
      .user_mode(user_mode), .pin_conflict(pin_conflict), .load_overrun(load_overrun));
   cfgld_flash_model cfgld_flash_model_inst (.clk(clk), .active_clk(active_clk), .flash_select_n(flash_select_n),
      .slow(slow), .host_drive(mode == CFGLD_MODE_PASSIVE), .config_reset_n(config_reset_n),
      .spi_clk_rise(spi_clk_rise), .spi_data(spi_data), .spi_data_valid(spi_data_valid));
   // clock, hang guard and output byte capture
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         report_and_stop();
      end
      if (cfg_valid === 1'h1 && cfg_ready) rx_q.push_back(cfg_data);
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // counts cycles until a watched output goes high, capped
   task automatic wait_hi(input int which, output int n);
      n = 0;
      while (watch[which] !== 1'h1 && n < 5000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic pulse(input int n);
      config_reset_n <= 1'h0;
      cyc(n);
      config_reset_n <= 1'h1;
      cyc(1);
   endtask
   task automatic chk_bytes(input logic [DATA_W-1:0] base);
      `CHK("byte count", 8, rx_q.size())
      foreach (rx_q[i]) `CHK("byte", base + DATA_W'(i), rx_q[i])
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // one cycle short of the minimum pulse must start nothing
   task automatic t_short();
      pulse(RESET_MIN_CYC - 1);
      cyc(400);
      `CHK("select", 1'h1, flash_select_n)
   endtask
   // full active load: delay, clock rate, bytes, completion, user entry
   task automatic t_active(input logic d, input logic s);
      int n;
      int p;
      mode <= CFGLD_MODE_ACTIVE;
      divide_by_eight_setting <= d;
      slow <= s;
      rx_q.delete();
      pulse(RESET_MIN_CYC);
      wait_hi(3, n);
      `CHK("first data delay", 1'h1, n >= FIRST_DATA_DELAY_CYC)
      wait_hi(0, n);
      p = 0;
      while (active_clk === 1'h1 && p < 50) begin
         cyc(1);
         p++;
      end
      `CHK("half period", d ? SLOW_HALF_CYC : ACTIVE_HALF_CYC, p)
      wait_hi(2, n);
      cyc(3);
      chk_bytes(8'ha0);
      wait_hi(1, n);
      `CHK("user delay", USER_DELAY_CYC + 1, n + 3)
      // a short pulse in user mode must leave it there
      pulse(RESET_MIN_CYC - 1);
      `CHK("user kept", 1'h1, user_mode)
      `CHK("complete kept", 1'h1, config_complete)
   endtask
   // tap load: fifo filled to refusal, user entry waits for the instruction
   task automatic t_tap();
      int n;
      mode <= CFGLD_MODE_TAP;
      tap_active <= 1'h1;
      cfg_ready <= 1'h0;
      rx_q.delete();
      pulse(RESET_MIN_CYC);
      cyc(FIRST_DATA_DELAY_CYC + 8);
      for (int i = 0; i < 9; i++) begin
         if (i == 6) begin
            cfg_ready <= 1'h1;
            tap_data_valid <= 1'h0;
            cyc(8);
            `CHK("overrun", 1'h1, load_overrun)
         end
         tap_data <= 8'hc0 + DATA_W'(i > 5 ? i - 1 : i);
         tap_data_valid <= 1'h1;
         cyc(1);
      end
      tap_data_valid <= 1'h0;
      wait_hi(2, n);
      cyc(3000);
      chk_bytes(8'hc0);
      `CHK("user early", 1'h0, user_mode)
      enter_user_instruction <= 1'h1;
      cyc(1);
      enter_user_instruction <= 1'h0;
      wait_hi(1, n);
      `CHK("tap user delay", 1'h1, n >= USER_DELAY_CYC && n <= USER_DELAY_CYC + 2)
      tap_active <= 1'h0;
   endtask
   // tap pins touched during a spi load (active) or its first-data wait (passive) raise the conflict flag; the load still ends
   task automatic t_conflict(input cfgld_mode_e m);
      int n;
      mode <= m;
      rx_q.delete();
      pulse(RESET_MIN_CYC);
      if (m == CFGLD_MODE_ACTIVE) wait_hi(3, n);
      else cyc(20);
      tap_active <= 1'h1;
      cyc(4);
      tap_active <= 1'h0;
      `CHK("conflict", 1'h1, pin_conflict)
      wait_hi(2, n);
      cyc(3);
      chk_bytes(m == CFGLD_MODE_PASSIVE ? 8'hb0 : 8'ha0);
   endtask
   initial begin
      cyc(2);
      reset <= 1'h0;
      t_short();
      t_active(1'h0, 1'h0);
      t_active(1'h1, 1'h1);
      t_tap();
      t_conflict(CFGLD_MODE_PASSIVE);
      t_conflict(CFGLD_MODE_ACTIVE);
      report_and_stop();
   end
endmodule
